/* File: verilog/prb_bank.sv */
// register bank: identity, interrupt flag/mask/live groups (mode without live, uv flag only), fuse mirrors
`timescale 1ns/100ps
`default_nettype none
module prb_bank
	import prb_pkg::*;
(
	input wire logic clock_i, // 100 MHz core clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic input_undervolt_reset_class_i, // input undervoltage crossing (async)
	input wire logic enter_off_i, // device entering off state, same domain
	input wire logic fuse_load_i, // fuse load strobe, same domain
	input wire logic [8*NUM_MIRROR-1:0] fuse_data_i, // programmed fuse bytes
	input wire logic [7:0] prog_code_fuse_i, // program code fuse byte
	input wire logic test_configuration_i, // test configuration active
	input wire prb_events_s event_i, // event pulses, same domain
	input wire prb_events_s live_i, // live conditions (async)
	input wire prb_req_s req_i, // register access request
	output logic [7:0] rdata_o, // read data, one cycle after rd
	output logic rvalid_o, // read data valid pulse
	output logic irq_o, // interrupt, active high
	output logic [7:0] test_flags_o // test-write register contents
);
	localparam int NUM_FLAG = 5;

	// flag/mask pairs held as arrays; index 0 sys_a, 1 therm, 2 mode, 3 ilim, 4 uv (flag only)
	logic [7:0] flag_r [NUM_FLAG];
	logic [7:0] mask_r [NUM_FLAG-1];
	logic [7:0] mirror_r [NUM_MIRROR];
	logic [7:0] prog_code_r;
	logic [7:0] test_flags_r;
	logic [7:0] rdata_r;
	logic rvalid_r;
	logic irq_r;
	logic uv_meta_r, uv_sync_r, uv_prev_r;
	prb_events_s live_meta_r, live_r;
	logic [7:0] evt [NUM_FLAG];
	logic [7:0] impl [NUM_FLAG];
	logic [7:0] flag_addr [NUM_FLAG];
	logic [7:0] mask_addr [NUM_FLAG-1];
	logic [7:0] mask_rst [NUM_FLAG-1];
	logic uv_rise;
	logic off_reset;

	// mirror index lookup, used by write and read decode
	function automatic int mirror_index(input logic [7:0] a);
		int idx;
		idx = -1;
		for (int k = 0; k < NUM_MIRROR; k++) begin
			if (MIRROR_ADDR[k] == a) begin
				idx = k;
			end
		end
		return idx;
	endfunction

	// tables tying each flag to its address and, except for uv, to its mask and mask reset value
	always_comb begin
		evt[0] = event_i.sys_a;
		evt[1] = event_i.therm;
		evt[2] = event_i.mode;
		evt[3] = event_i.ilim;
		evt[4] = event_i.uv;
		impl[0] = SYS_A_BITS;
		impl[1] = 8'hff;
		impl[2] = REG_BITS;
		impl[3] = REG_BITS;
		impl[4] = REG_BITS;
		flag_addr[0] = ADDR_SYS_FLAGS_A;
		flag_addr[1] = ADDR_THERM_FLAGS;
		flag_addr[2] = ADDR_MODE_FLAGS;
		flag_addr[3] = ADDR_ILIM_FLAGS;
		flag_addr[4] = ADDR_UV_FLAGS;
		mask_addr[0] = ADDR_SYS_MASK_A;
		mask_addr[1] = ADDR_THERM_MASK;
		mask_addr[2] = ADDR_MODE_MASK;
		mask_addr[3] = ADDR_ILIM_MASK;
		mask_rst[0] = RST_SYS_MASK_A;
		mask_rst[1] = RST_THERM_MASK;
		mask_rst[2] = RST_REG_MASK;
		mask_rst[3] = RST_REG_MASK;
	end

	// two-stage synchronisers for the asynchronous inputs
	// only the second stage is read, so a metastable first stage never reaches logic
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			uv_meta_r <= 1'b0;
			uv_sync_r <= 1'b0;
			uv_prev_r <= 1'b0;
			live_meta_r <= '0;
			live_r <= '0;
		end else begin
			uv_meta_r <= input_undervolt_reset_class_i;
			uv_sync_r <= uv_meta_r;
			uv_prev_r <= uv_sync_r;
			live_meta_r <= live_i;
			live_r <= live_meta_r;
		end
	end

	// undervoltage crossing acts on its rising edge only
	assign uv_rise = uv_sync_r & ~uv_prev_r;
	// flags and masks belong to the undervoltage class and to the off class
	assign off_reset = rst_i | uv_rise | enter_off_i;

	// flag registers: event sets, write-one clears, set wins
	// the class reset beats both set and clear, so an off entry never leaves a stale flag
	generate
		for (genvar g = 0; g < NUM_FLAG; g++) begin : g_flag
			always_ff @(posedge clock_i) begin
				if (off_reset) begin
					flag_r[g] <= RST_FLAGS;
				end else begin
					flag_r[g] <= ((req_i.wr && req_i.addr == flag_addr[g]) ? (flag_r[g] & ~req_i.wdata) : flag_r[g])
						| (evt[g] & impl[g]);
				end
			end
		end
		// writes to reserved mask bits are dropped; reserved reset bits are cleared by the first write to that mask
		for (genvar m = 0; m < NUM_FLAG-1; m++) begin : g_mask
			always_ff @(posedge clock_i) begin
				if (off_reset) begin
					mask_r[m] <= mask_rst[m];
				end else if (req_i.wr && req_i.addr == mask_addr[m]) begin
					mask_r[m] <= req_i.wdata & impl[m];
				end
			end
		end
	endgenerate

	// fuse mirrors: loaded from fuses, writable by software between loads
	// a software write is lost on the next load or reset, the fuse stays the reference
	always_ff @(posedge clock_i) begin
		if (rst_i || fuse_load_i) begin
			for (int k = 0; k < NUM_MIRROR; k++) begin
				mirror_r[k] <= fuse_data_i[8*k +: 8];
			end
			prog_code_r <= prog_code_fuse_i;
		end else if (req_i.wr && mirror_index(req_i.addr) >= 0) begin
			mirror_r[mirror_index(req_i.addr)] <= req_i.wdata;
		end
	end

	// test-write register
	// an off entry leaves it alone; only reset and undervoltage clear it
	always_ff @(posedge clock_i) begin
		if (rst_i || uv_rise) begin
			test_flags_r <= RST_TEST_FLAGS;
		end else if (req_i.wr && req_i.addr == ADDR_TEST_FLAGS && test_configuration_i) begin
			test_flags_r <= req_i.wdata;
		end
	end

	// read mux registered; unmapped addresses read zero
	// the answer comes one edge after the request, so a write in the same cycle is not yet seen
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			rdata_r <= 8'h00;
			rvalid_r <= 1'b0;
		end else begin
			rvalid_r <= req_i.rd;
			if (req_i.rd) begin
				unique case (req_i.addr)
					ADDR_DEVICE_IDENTITY: rdata_r <= {DEV_FAMILY, DEV_VARIANT};
					ADDR_SILICON_REVISION: rdata_r <= SILICON_REV;
					ADDR_SYS_FLAGS_A: rdata_r <= flag_r[0];
					ADDR_SYS_MASK_A: rdata_r <= mask_r[0];
					ADDR_SYS_LIVE_A: rdata_r <= live_r.sys_a & SYS_A_LIVE_BITS;
					ADDR_THERM_FLAGS: rdata_r <= flag_r[1];
					ADDR_THERM_MASK: rdata_r <= mask_r[1];
					ADDR_THERM_LIVE: rdata_r <= live_r.therm;
					ADDR_MODE_FLAGS: rdata_r <= flag_r[2];
					ADDR_MODE_MASK: rdata_r <= mask_r[2];
					ADDR_ILIM_FLAGS: rdata_r <= flag_r[3];
					ADDR_ILIM_MASK: rdata_r <= mask_r[3];
					ADDR_ILIM_LIVE: rdata_r <= live_r.ilim & REG_BITS;
					ADDR_UV_FLAGS: rdata_r <= flag_r[4];
					ADDR_TEST_FLAGS: rdata_r <= test_flags_r;
					default: rdata_r <= (mirror_index(req_i.addr) >= 0) ? mirror_r[mirror_index(req_i.addr)] : 8'h00;
				endcase
			end
		end
	end

	// per-group pending bits; the uv group has no mask register and is always enabled
	logic [NUM_FLAG-1:0] pend;
	generate
		for (genvar p = 0; p < NUM_FLAG-1; p++) begin : g_pend
			assign pend[p] = |(flag_r[p] & ~mask_r[p]);
		end
	endgenerate
	assign pend[NUM_FLAG-1] = |flag_r[NUM_FLAG-1];

	// interrupt: registered so the pin comes straight from a flop
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |pend;
		end
	end

	assign rdata_o = rdata_r;
	assign rvalid_o = rvalid_r;
	assign irq_o = irq_r;
	assign test_flags_o = test_flags_r;

	// checks, grouped by rule; bits 0 and 2 of the thermal flags serve as probes
	// clear-by-one: a one clears, a zero keeps
	AST_W1C_CLEARS: assert property (@(posedge clock_i) disable iff (rst_i)
		(req_i.wr && req_i.addr == ADDR_THERM_FLAGS && req_i.wdata[0] && !event_i.therm[0] && !off_reset)
		|=> !flag_r[1][0]) else $error("flag not cleared by one");
	AST_W1C_KEEPS: assert property (@(posedge clock_i) disable iff (rst_i)
		(req_i.wr && req_i.addr == ADDR_THERM_FLAGS && !req_i.wdata[0] && flag_r[1][0] && !off_reset)
		|=> flag_r[1][0]) else $error("flag cleared by zero write");
	// a read returns the flag as it stood at the taking edge
	AST_W1C_READ: assert property (@(posedge clock_i) disable iff (rst_i)
		(req_i.rd && req_i.addr == ADDR_THERM_FLAGS)
		|=> (rvalid_o && rdata_o == $past(flag_r[1]))) else $error("flag read wrong");
	// an event and a clear in one cycle leave the flag set
	AST_SET_WINS: assert property (@(posedge clock_i) disable iff (rst_i)
		(req_i.wr && req_i.addr == ADDR_THERM_FLAGS && req_i.wdata[2] && event_i.therm[2] && !off_reset)
		|=> flag_r[1][2]) else $error("clear beat the event");

	// undervoltage class: flags, masks and the test register
	AST_UV_RESET: assert property (@(posedge clock_i) disable iff (rst_i)
		uv_rise |=> (flag_r[0] == RST_FLAGS && mask_r[1] == RST_THERM_MASK)) else $error("uv reset missed");
	AST_UV_TEST_REG: assert property (@(posedge clock_i) disable iff (rst_i)
		uv_rise |=> test_flags_r == RST_TEST_FLAGS) else $error("test register kept over uv");

	// flags and masks of every group return to default on off entry and on uv
	generate
		for (genvar c = 0; c < NUM_FLAG; c++) begin : g_flag_chk
			AST_CLASS_FLAG: assert property (@(posedge clock_i) disable iff (rst_i)
				(enter_off_i || uv_rise) |=> flag_r[c] == RST_FLAGS) else $error("flag kept over class reset");
		end
		for (genvar n = 0; n < NUM_FLAG-1; n++) begin : g_mask_chk
			AST_CLASS_MASK: assert property (@(posedge clock_i) disable iff (rst_i)
				(enter_off_i || uv_rise) |=> mask_r[n] == mask_rst[n]) else $error("mask kept over class reset");
		end
	endgenerate

	// fuse mirrors follow their fuse bytes after a load
	AST_FUSE_LOAD: assert property (@(posedge clock_i) disable iff (rst_i)
		fuse_load_i |=> mirror_r[0] == $past(fuse_data_i[7:0])) else $error("mirror not loaded");
	generate
		for (genvar a = 0; a < NUM_MIRROR; a++) begin : g_mirror_chk
			AST_FUSE_EACH: assert property (@(posedge clock_i) disable iff (rst_i)
				fuse_load_i |=> mirror_r[a] == $past(fuse_data_i[8*a +: 8])) else $error("mirror byte not loaded");
		end
	endgenerate

	// off entry: class reset, test register untouched
	AST_OFF_RESET: assert property (@(posedge clock_i) disable iff (rst_i)
		enter_off_i |=> (mask_r[2] == RST_REG_MASK && flag_r[3] == RST_FLAGS)) else $error("off reset missed");
	AST_OFF_TEST_HOLD: assert property (@(posedge clock_i) disable iff (rst_i)
		(enter_off_i && !uv_rise && !(req_i.wr && req_i.addr == ADDR_TEST_FLAGS))
		|=> $stable(test_flags_r)) else $error("test register changed on off entry");

	// fuse-coded bits take the fuse value on reset as well as on load
	AST_PROG_FUSE: assert property (@(posedge clock_i) disable iff (rst_i)
		fuse_load_i |=> prog_code_r == $past(prog_code_fuse_i)) else $error("code not from fuse");
	AST_RESET_FROM_FUSE: assert property (@(posedge clock_i)
		rst_i |=> (prog_code_r == $past(prog_code_fuse_i) && mirror_r[0] == $past(fuse_data_i[7:0])))
		else $error("reset value not from fuse");

	// zero defaults after reset
	AST_ZERO_DEFAULT: assert property (@(posedge clock_i)
		rst_i |=> flag_r[4] == 8'h00) else $error("flag not zero after reset");
	AST_ZERO_ALL: assert property (@(posedge clock_i)
		rst_i |=> ((flag_r[0] | flag_r[1] | flag_r[2] | flag_r[3]) == 8'h00 && test_flags_r == RST_TEST_FLAGS))
		else $error("zero default missed");

	// test register: locked outside the test configuration, written inside it
	AST_TEST_LOCK: assert property (@(posedge clock_i) disable iff (rst_i)
		(!test_configuration_i && !uv_rise) |=> $stable(test_flags_r)) else $error("test register written");
	AST_TEST_WRITE: assert property (@(posedge clock_i) disable iff (rst_i)
		(req_i.wr && req_i.addr == ADDR_TEST_FLAGS && test_configuration_i && !uv_rise)
		|=> test_flags_r == $past(req_i.wdata)) else $error("test write lost");

	// interrupt, events and live bits
	AST_IRQ_MASK: assert property (@(posedge clock_i) disable iff (rst_i)
		(flag_r[1] & ~mask_r[1]) != 8'h00 |=> irq_o) else $error("irq missing");
	AST_IRQ_QUIET: assert property (@(posedge clock_i) disable iff (rst_i)
		((flag_r[0] & ~mask_r[0]) == 8'h00 && (flag_r[1] & ~mask_r[1]) == 8'h00
			&& (flag_r[2] & ~mask_r[2]) == 8'h00 && (flag_r[3] & ~mask_r[3]) == 8'h00 && flag_r[4] == 8'h00)
		|=> !irq_o) else $error("irq without an unmasked flag");
	AST_IRQ_UV: assert property (@(posedge clock_i) disable iff (rst_i)
		flag_r[4] != 8'h00 |=> irq_o) else $error("uv flag without irq");
	AST_EVENT_SET: assert property (@(posedge clock_i) disable iff (rst_i)
		(event_i.mode[0] && !off_reset) |=> flag_r[2][0]) else $error("event lost");
	AST_LIVE_FOLLOW: assert property (@(posedge clock_i) disable iff (rst_i)
		(req_i.rd && req_i.addr == ADDR_THERM_LIVE) |=> rdata_o == $past(live_r.therm))
		else $error("live bits stale");
	AST_LIVE_ILIM: assert property (@(posedge clock_i) disable iff (rst_i)
		(req_i.rd && req_i.addr == ADDR_ILIM_LIVE) |=> rdata_o == ($past(live_r.ilim) & REG_BITS))
		else $error("current limit live bits stale");

	// main scenarios
	COV_CLEAR: cover property (@(posedge clock_i) req_i.wr && req_i.addr == ADDR_SYS_FLAGS_A && flag_r[0] != 8'h00);
	COV_IRQ: cover property (@(posedge clock_i) !irq_o ##1 irq_o);
	COV_TEST_WRITE: cover property (@(posedge clock_i) req_i.wr && req_i.addr == ADDR_TEST_FLAGS && test_configuration_i);
	COV_UV: cover property (@(posedge clock_i) uv_rise);
	COV_SET_WINS: cover property (@(posedge clock_i) req_i.wr && req_i.addr == ADDR_THERM_FLAGS && event_i.therm != 8'h00);
endmodule
`default_nettype wire

/* File: verilog/prb_pkg.sv */
// package for the power-management status register bank
package prb_pkg;
	// register offsets
	localparam logic [7:0] ADDR_DEVICE_IDENTITY = 8'h01;
	localparam logic [7:0] ADDR_SILICON_REVISION = 8'h02;
	localparam logic [7:0] ADDR_SYS_FLAGS_A = 8'h04;
	localparam logic [7:0] ADDR_SYS_MASK_A = 8'h05;
	localparam logic [7:0] ADDR_SYS_LIVE_A = 8'h06;
	localparam logic [7:0] ADDR_THERM_FLAGS = 8'h07;
	localparam logic [7:0] ADDR_THERM_MASK = 8'h08;
	localparam logic [7:0] ADDR_THERM_LIVE = 8'h09;
	localparam logic [7:0] ADDR_MODE_FLAGS = 8'h0a;
	localparam logic [7:0] ADDR_MODE_MASK = 8'h0b;
	localparam logic [7:0] ADDR_ILIM_FLAGS = 8'h0c;
	localparam logic [7:0] ADDR_ILIM_MASK = 8'h0d;
	localparam logic [7:0] ADDR_ILIM_LIVE = 8'h0e;
	localparam logic [7:0] ADDR_UV_FLAGS = 8'h12;
	localparam logic [7:0] ADDR_TEST_FLAGS = 8'h2a;
	// mirror count; mirror address table below
	localparam int NUM_MIRROR = 13;
	localparam logic [7:0] MIRROR_ADDR [NUM_MIRROR] = '{8'hbe, 8'hbf, 8'hc8, 8'hca, 8'hcc, 8'hce, 8'hcf,
		8'hd0, 8'hd1, 8'hd2, 8'hd4, 8'hd5, 8'hd6};
	// reset values
	localparam logic [7:0] RST_FLAGS = 8'h00;
	localparam logic [7:0] RST_SYS_MASK_A = 8'hfb;
	localparam logic [7:0] RST_THERM_MASK = 8'hff;
	localparam logic [7:0] RST_REG_MASK = 8'h4f;
	localparam logic [7:0] RST_TEST_FLAGS = 8'h00;
	// implemented bits of the per-regulator registers and of the first system group
	localparam logic [7:0] REG_BITS = 8'h0f;
	localparam logic [7:0] SYS_A_BITS = 8'hfb;
	// live bits of the first system group that carry a condition
	localparam logic [7:0] SYS_A_LIVE_BITS = 8'h03;
	// identity: upper nibble fixed device family, values arbitrary
	localparam logic [3:0] DEV_FAMILY = 4'h0;
	localparam logic [3:0] DEV_VARIANT = 4'h0;
	localparam logic [7:0] SILICON_REV = 8'h10;
	// grouping of the raw event inputs
	typedef struct packed {
		logic [7:0] sys_a;
		logic [7:0] therm;
		logic [7:0] mode;
		logic [7:0] ilim;
		logic [7:0] uv;
	} prb_events_s;
	// register access port
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} prb_req_s;
endpackage

/* File: bench/testbench.sv */
// self-checking bench for the status register bank
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, msg) begin samples_checked++; if ((got) !== (exp)) begin err_count++; \
	$display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp); end end
module testbench;
	import prb_pkg::*;
	logic clock_i = 1'b0;
	logic rst_i = 1'b1;
	logic input_undervolt_reset_class_i = 1'b0;
	logic enter_off_i = 1'b0;
	logic fuse_load_i = 1'b0;
	logic [8*NUM_MIRROR-1:0] fuse_data_i = '0;
	logic [7:0] prog_code_fuse_i = 8'h00;
	logic test_configuration_i = 1'b0;
	prb_events_s event_i = '0;
	prb_events_s live_i = '0;
	prb_req_s req_i = '0;
	logic [7:0] rdata_o;
	logic rvalid_o;
	logic irq_o;
	logic [7:0] test_flags_o;
	int err_count = 0;
	int samples_checked = 0;
	int cycles = 0;
	prb_bank i_dut (.clock_i(clock_i), .rst_i(rst_i), .input_undervolt_reset_class_i(input_undervolt_reset_class_i), .enter_off_i(enter_off_i),
		.fuse_load_i(fuse_load_i), .fuse_data_i(fuse_data_i), .prog_code_fuse_i(prog_code_fuse_i),
		.test_configuration_i(test_configuration_i), .event_i(event_i), .live_i(live_i), .req_i(req_i),
		.rdata_o(rdata_o), .rvalid_o(rvalid_o), .irq_o(irq_o), .test_flags_o(test_flags_o));
	// 100 MHz clock
	always #5 clock_i = ~clock_i;
	// hang guard: the whole run needs well under a thousand cycles
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 5000) begin
			err_count++;
			$display("BAD t=%0t timeout", $time);
			wrap_up();
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask
	// one write, strobe held for exactly one taking edge, then an idle edge before the next request
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req_i = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		tick(1);
		req_i = '0;
		tick(1);
	endtask
	// one read, answer checked just after the taking edge while rvalid stands
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		req_i = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		tick(1);
		req_i = '0;
		`CHK(rvalid_o, 1'b1, "rvalid")
		`CHK(rdata_o, exp, "rdata")
		tick(1);
	endtask
	task automatic t_reset_values();
		rd_chk(ADDR_SYS_MASK_A, 8'hfb);
		rd_chk(ADDR_THERM_MASK, 8'hff);
		rd_chk(ADDR_MODE_MASK, RST_REG_MASK);
		rd_chk(ADDR_ILIM_MASK, RST_REG_MASK);
		rd_chk(ADDR_THERM_FLAGS, 8'h00);
		rd_chk(8'h3f, 8'h00);
		$display("test reset values done");
	endtask
	task automatic t_w1c_irq();
		event_i.therm = 8'h03;
		tick(1);
		event_i = '0;
		tick(2);
		`CHK(irq_o, 1'b0, "irq masked")
		rd_chk(ADDR_THERM_FLAGS, 8'h03);
		wr(ADDR_THERM_FLAGS, 8'h02);
		rd_chk(ADDR_THERM_FLAGS, 8'h01);
		wr(ADDR_THERM_MASK, 8'hfe);
		tick(2);
		`CHK(irq_o, 1'b1, "irq unmasked")
		wr(ADDR_THERM_FLAGS, 8'h01);
		tick(2);
		`CHK(irq_o, 1'b0, "irq after clear")
		// event and clear in one cycle: the set wins
		event_i.therm = 8'h04;
		req_i = '{rd: 1'b0, wr: 1'b1, addr: ADDR_THERM_FLAGS, wdata: 8'h04};
		tick(1);
		event_i = '0;
		req_i = '0;
		tick(1);
		rd_chk(ADDR_THERM_FLAGS, 8'h04);
		wr(ADDR_THERM_FLAGS, 8'h04);
		rd_chk(ADDR_THERM_FLAGS, 8'h00);
		// undervoltage flags have no mask and always raise the interrupt
		event_i.uv = 8'h01;
		tick(1);
		event_i = '0;
		tick(2);
		`CHK(irq_o, 1'b1, "irq from uv flag")
		rd_chk(ADDR_UV_FLAGS, 8'h01);
		wr(ADDR_UV_FLAGS, 8'h01);
		tick(2);
		`CHK(irq_o, 1'b0, "irq after uv clear")
		$display("test w1c and irq done");
	endtask
	task automatic t_mirrors();
		for (int k = 0; k < NUM_MIRROR; k++) fuse_data_i[8*k +: 8] = 8'h31 + 8'(k * 7);
		fuse_load_i = 1'b1;
		tick(1);
		fuse_load_i = 1'b0;
		tick(1);
		for (int k = 0; k < NUM_MIRROR; k++) rd_chk(MIRROR_ADDR[k], 8'h31 + 8'(k * 7));
		// a software write stands until the next load brings the fuse byte back
		wr(MIRROR_ADDR[0], 8'h5a);
		rd_chk(MIRROR_ADDR[0], 8'h5a);
		fuse_load_i = 1'b1;
		tick(1);
		fuse_load_i = 1'b0;
		rd_chk(MIRROR_ADDR[0], 8'h31);
		$display("test mirrors done");
	endtask
	task automatic t_off();
		event_i.therm = 8'h80;
		wr(ADDR_THERM_MASK, 8'h00);
		event_i = '0;
		rd_chk(ADDR_THERM_FLAGS, 8'h80);
		`CHK(irq_o, 1'b1, "irq before off")
		enter_off_i = 1'b1;
		tick(1);
		enter_off_i = 1'b0;
		tick(1);
		rd_chk(ADDR_THERM_FLAGS, 8'h00);
		rd_chk(ADDR_THERM_MASK, 8'hff);
		`CHK(irq_o, 1'b0, "irq after off")
		$display("test off entry done");
	endtask
	task automatic t_test_reg_uv();
		wr(ADDR_TEST_FLAGS, 8'h05);
		tick(1);
		`CHK(test_flags_o, 8'h00, "test reg locked")
		test_configuration_i = 1'b1;
		wr(ADDR_TEST_FLAGS, 8'h05);
		tick(1);
		`CHK(test_flags_o, 8'h05, "test reg written")
		test_configuration_i = 1'b0;
		wr(ADDR_SYS_MASK_A, 8'h00);
		input_undervolt_reset_class_i = 1'b1;
		tick(5);
		`CHK(test_flags_o, 8'h00, "test reg uv")
		rd_chk(ADDR_SYS_MASK_A, 8'hfb);
		input_undervolt_reset_class_i = 1'b0;
		$display("test undervoltage done");
	endtask
	task automatic t_live();
		live_i.therm = 8'ha5;
		live_i.sys_a = 8'hff;
		live_i.ilim = 8'hff;
		tick(4);
		rd_chk(ADDR_THERM_LIVE, 8'ha5);
		rd_chk(ADDR_SYS_LIVE_A, 8'h03);
		rd_chk(ADDR_ILIM_LIVE, 8'h0f);
		live_i = '0;
		tick(4);
		rd_chk(ADDR_THERM_LIVE, 8'h00);
		$display("test live done");
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		tick(8);
		rst_i = 1'b0;
		t_reset_values();
		t_w1c_irq();
		t_mirrors();
		t_off();
		t_test_reg_uv();
		t_live();
		wrap_up();
	end
endmodule
`default_nettype wire
